// ### rtl/hotswap_control_alert_fault_regs.sv
// Control, alert-enable and fault-log registers of a hot swap controller,
// with turn-on pin handling, fault auto-retry and the alert output.
// Assumes a byte command port on the link clock and fault pulses on mclk.
`include "hotswap_consts.svh"

module hotswap_control_alert_fault_regs #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_MS * (`MCLK_HZ / 1000),
  parameter int RETRY_CYCLES = `RETRY_MS * (`MCLK_HZ / 1000),
  parameter int TIMER_TICK_CYCLES = `TIMER_TICK_DEFAULT
) (
  // Clocks and reset.
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic linkClk,
  // Register command port, link clock domain.
  input wire logic cmdStrobe,
  input wire logic cmdWrite,
  input wire logic cmdGroup,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdData,
  output logic cmdBusy,
  output logic rspValid,
  output logic [7:0] rspData,
  // Turn-on pin, asynchronous.
  input wire logic turnOnPin,
  // Fault and converter events, one-cycle pulses on mclk.
  input wire logic ovEvent,
  input wire logic uvEvent,
  input wire logic ocEvent,
  input wire logic powerBadEvent,
  input wire logic switchShortEvent,
  input wire logic switchBadEvent,
  input wire logic nvWriteDoneEvent,
  input wire logic [7:0] adcAlarmEvent,
  // Controls to the analog side and the alert pin.
  output logic switchOn,
  output logic [1:0] goodThresholdSel,
  output logic [1:0] lowThresholdSel,
  output logic [1:0] highThresholdSel,
  output logic [1:0] supplyRangeSel,
  output logic alert_n
);

  localparam hotswap_pkg::count_t DEB_LAST = 24'(DEBOUNCE_CYCLES - 1);
  localparam hotswap_pkg::count_t RETRY_LAST = 24'(RETRY_CYCLES - 1);
  localparam hotswap_pkg::count_t OC_LAST = 24'(`OC_RETRY_TICKS * TIMER_TICK_CYCLES - 1);

  logic [15:0] ctrl;
  logic [15:0] alertEn;
  hotswap_pkg::byte_t fault;
  hotswap_pkg::byte_t next_fault;
  hotswap_pkg::byte_t alertCtrl;
  hotswap_pkg::byte_t readData;
  hotswap_pkg::byte_t holdAddr;
  hotswap_pkg::byte_t holdData;
  hotswap_pkg::byte_t setVec;
  logic holdWrite, holdGroup, reqTgl, ackTgl;
  logic ackSync1, ackSync2, ackSeen;
  logic reqSync1, reqSync2, reqSeen;
  logic accessGo, writeOk;
  logic wrCtrlHi, wrCtrlLo, wrAlertHi, wrAlertLo, wrFault, wrActl;
  logic pinSync1, pinSync2, pinPrev, pinChange, pinActive;
  logic pinGrant, pinGrantPrev, grantRise, grantFall;
  hotswap_pkg::count_t debCnt;
  hotswap_pkg::count_t retryCnt;
  hotswap_pkg::count_t retryLimit;
  hotswap_pkg::retry_state_e retryState;
  logic trip, tripRetry;
  logic alertSet, alertPending;

  // Link side: capture a command and raise the request toggle. Fields stay
  // frozen until the answer returns, so mclk may read them without syncing.
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      holdAddr <= 8'h00;
      holdData <= 8'h00;
      holdWrite <= 1'b0;
      holdGroup <= 1'b0;
      reqTgl <= 1'b0;
      cmdBusy <= 1'b0;
      ackSeen <= 1'b0;
    end else if (!cmdBusy && cmdStrobe) begin
      holdAddr <= cmdAddr;
      holdData <= cmdData;
      holdWrite <= cmdWrite;
      holdGroup <= cmdGroup;
      reqTgl <= ~reqTgl;
      cmdBusy <= 1'b1;
    end else if (cmdBusy && (ackSync2 != ackSeen)) begin
      cmdBusy <= 1'b0;
      ackSeen <= ackSync2;
    end
  end

  // Link side: bring back the acknowledge toggle and present read data.
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      ackSync1 <= 1'b0;
      ackSync2 <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 8'h00;
    end else begin
      ackSync1 <= ackTgl;
      ackSync2 <= ackSync1;
      rspValid <= cmdBusy && (ackSync2 != ackSeen);
      if (cmdBusy && (ackSync2 != ackSeen)) begin
        rspData <= readData; // Stable: written on the same mclk edge that toggled the acknowledge.
      end
    end
  end

  // System side: detect a new request and toggle the acknowledge back.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reqSync1 <= 1'b0;
      reqSync2 <= 1'b0;
      reqSeen <= 1'b0;
      ackTgl <= 1'b0;
    end else begin
      reqSync1 <= reqTgl;
      reqSync2 <= reqSync1;
      reqSeen <= reqSync2;
      if (accessGo) begin
        ackTgl <= ~ackTgl;
      end
    end
  end

  // Address decode; each command byte reaches one register byte.
  assign accessGo = reqSync2 != reqSeen;
  assign writeOk = accessGo && holdWrite && (!holdGroup || ctrl[`CTRL_GROUP_BIT]);
  assign wrCtrlHi = writeOk && (holdAddr == `ADDR_CTRL_HI);
  assign wrCtrlLo = writeOk && (holdAddr == `ADDR_CTRL_LO);
  assign wrAlertHi = writeOk && (holdAddr == `ADDR_ALERT_HI);
  assign wrAlertLo = writeOk && (holdAddr == `ADDR_ALERT_LO);
  assign wrFault = writeOk && (holdAddr == `ADDR_FAULT);
  assign wrActl = writeOk && (holdAddr == `ADDR_ALERT_CTRL);

  // Read data is latched on the access; unmapped codes read as zero.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      readData <= 8'h00;
    end else if (accessGo && !holdWrite) begin
      case (holdAddr)
        `ADDR_CTRL_HI: readData <= ctrl[15:8];
        `ADDR_CTRL_LO: readData <= ctrl[7:0];
        `ADDR_ALERT_HI: readData <= alertEn[15:8];
        `ADDR_ALERT_LO: readData <= alertEn[7:0];
        `ADDR_FAULT: readData <= fault;
        `ADDR_ALERT_CTRL: readData <= alertCtrl;
        default: readData <= 8'h00;
      endcase
    end
  end

  // Turn-on pin: two-stage synchroniser, then edge and level detection.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pinSync1 <= 1'b0;
      pinSync2 <= 1'b0;
      pinPrev <= 1'b0;
    end else begin
      pinSync1 <= turnOnPin;
      pinSync2 <= pinSync1;
      pinPrev <= pinSync2;
    end
  end

  assign pinChange = pinSync2 != pinPrev;
  assign pinActive = (pinSync2 == ctrl[`CTRL_POL_BIT]);

  // Debounce: a glitch shorter than the window restarts the count, so a
  // bouncing contact never grants the switch early.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      debCnt <= 24'h00_0000;
      pinGrant <= 1'b0;
      pinGrantPrev <= 1'b0;
    end else begin
      pinGrantPrev <= pinGrant;
      if (!pinActive) begin
        debCnt <= 24'h00_0000;
        pinGrant <= 1'b0;
      end else if (!ctrl[`CTRL_DELAY_BIT] || (debCnt == DEB_LAST)) begin
        pinGrant <= 1'b1;
      end else begin
        debCnt <= debCnt + 24'h00_0001;
      end
    end
  end

  assign grantRise = pinGrant && !pinGrantPrev;
  assign grantFall = !pinGrant && pinGrantPrev;

  // Control register. The pin moves the switch bit on its edges only, and a
  // software write in the same cycle wins, so the last command stands.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `RST_CTRL;
    end else begin
      if (grantRise) begin
        ctrl[`CTRL_SWITCH_BIT] <= 1'b1;
      end else if (grantFall) begin
        ctrl[`CTRL_SWITCH_BIT] <= 1'b0;
      end
      if (wrCtrlHi) begin
        ctrl[15:8] <= holdData;
      end
      if (wrCtrlLo) begin
        ctrl[7:0] <= holdData;
      end
    end
  end

  // Threshold and range selections go straight from the register to the
  // analog side; the encodings are decoded there.
  assign goodThresholdSel = ctrl[`CTRL_GOOD_FIELD];
  assign lowThresholdSel = ctrl[`CTRL_LOW_FIELD];
  assign highThresholdSel = ctrl[`CTRL_HIGH_FIELD];
  assign supplyRangeSel = ctrl[`CTRL_RANGE_FIELD];

  // Alert enable and alert-control registers. The clear bit reads back zero.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      alertEn <= `RST_ALERT;
      alertCtrl <= `RST_ALERT_CTRL;
    end else begin
      if (wrAlertHi) begin
        alertEn[15:8] <= holdData;
      end
      if (wrAlertLo) begin
        alertEn[7:0] <= holdData;
      end
      if (wrActl) begin
        alertCtrl <= holdData & ~(8'h01 << `ACTL_CLEAR_BIT);
      end
    end
  end

  // Fault log sources in bit order.
  assign setVec = {nvWriteDoneEvent, switchBadEvent, switchShortEvent, pinChange,
                   powerBadEvent, ocEvent, uvEvent, ovEvent};

  // Fault log next value: pin clear, then software write, then new events,
  // so a fault arriving with a clear is never lost.
  always_comb begin
    next_fault = fault;
    if (pinChange && !ctrl[`CTRL_MASK_BIT]) begin
      next_fault = 8'h00;
    end
    if (wrFault) begin
      next_fault = holdData;
    end
    next_fault = next_fault | setVec;
  end

  // Fault log register.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fault <= `RST_FAULT;
    end else begin
      fault <= next_fault;
    end
  end

  // Alert: any enabled event sets the pending flag; a clear in the same cycle
  // loses to it. Forcing drives the pin low regardless of pending state.
  assign alertSet = |(setVec & alertEn[`ALERT_FAULT_FIELD])
                  || |(adcAlarmEvent & alertEn[`ALERT_ADC_FIELD]);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      alertPending <= 1'b0;
      alert_n <= 1'b1;
    end else begin
      if (alertSet) begin
        alertPending <= 1'b1;
      end else if (wrActl && holdData[`ACTL_CLEAR_BIT]) begin
        alertPending <= 1'b0;
      end
      alert_n <= !(alertPending || alertCtrl[`ACTL_FORCE_BIT]);
    end
  end

  // Fault trip and whether its retry is enabled; overvoltage or undervoltage
  // in the same cycle as overcurrent take the RETRY_LAST wait, not OC_LAST.
  assign trip = ovEvent || uvEvent || ocEvent;
  assign tripRetry = (ovEvent && ctrl[`CTRL_OV_RETRY_BIT])
                  || (uvEvent && ctrl[`CTRL_UV_RETRY_BIT])
                  || (ocEvent && ctrl[`CTRL_OC_RETRY_BIT]);

  // Retry state: a trip drops the switch; with retry enabled it waits and
  // returns, otherwise it holds off until a new on command arrives.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      retryState <= hotswap_pkg::FS_RUN;
      retryCnt <= 24'h00_0000;
      retryLimit <= 24'h00_0000;
    end else if (trip) begin
      retryCnt <= 24'h00_0000;
      retryLimit <= (ovEvent || uvEvent) ? RETRY_LAST : OC_LAST;
      retryState <= tripRetry ? hotswap_pkg::FS_WAIT : hotswap_pkg::FS_HOLD;
    end else begin
      unique case (retryState)
        hotswap_pkg::FS_RUN: begin
          retryCnt <= 24'h00_0000;
        end
        hotswap_pkg::FS_WAIT: begin
          if (retryCnt == retryLimit) begin
            retryState <= hotswap_pkg::FS_RUN;
          end else begin
            retryCnt <= retryCnt + 24'h00_0001;
          end
        end
        hotswap_pkg::FS_HOLD: begin
          if (grantRise || (wrCtrlHi && holdData[`SWITCH_DATA_BIT])) begin
            retryState <= hotswap_pkg::FS_RUN;
          end
        end
      endcase
    end
  end

  // Switch drive: commanded on and not held off by a fault.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      switchOn <= 1'b0;
    end else begin
      switchOn <= ctrl[`CTRL_SWITCH_BIT] && (retryState == hotswap_pkg::FS_RUN);
    end
  end

  // Checks on the behaviour above.
  maskKeep_a: assert property (@(posedge mclk) disable iff (!arst_n)
    pinChange && ctrl[`CTRL_MASK_BIT] && !wrFault |=> ((fault & $past(fault)) == $past(fault)))
    else $error("masked pin change cleared the fault log");

  debounceLen_a: assert property (@(posedge mclk) disable iff (!arst_n)
    pinActive && ctrl[`CTRL_DELAY_BIT] && !pinGrant && debCnt == 24'h00_0000
    |=> !pinGrant)
    else $error("debounced turn-on granted too early");

  immediateOn_a: assert property (@(posedge mclk) disable iff (!arst_n)
    pinActive && !ctrl[`CTRL_DELAY_BIT] && !pinGrant
    |=> pinGrant ##1 (ctrl[`CTRL_SWITCH_BIT] || $past(wrCtrlHi)))
    else $error("undelayed turn-on not granted next cycle");

  pinPolarity_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (pinSync2 != ctrl[`CTRL_POL_BIT]) |=> !pinGrant)
    else $error("inactive pin level granted turn-on");

  groupBlock_a: assert property (@(posedge mclk) disable iff (!arst_n)
    accessGo && holdWrite && holdGroup && !ctrl[`CTRL_GROUP_BIT]
    && holdAddr == `ADDR_ALERT_HI |=> alertEn == $past(alertEn))
    else $error("group write accepted while disabled");

  switchWrite_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wrCtrlHi |=> ctrl[`CTRL_SWITCH_BIT] == $past(holdData[`SWITCH_DATA_BIT]))
    else $error("switch command write not applied");

  ocRetry_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ocEvent && !ovEvent && !uvEvent && ctrl[`CTRL_OC_RETRY_BIT]
    |=> retryState == hotswap_pkg::FS_WAIT && retryLimit == OC_LAST)
    else $error("overcurrent retry wait not started");

  uvRetry_a: assert property (@(posedge mclk) disable iff (!arst_n)
    uvEvent && ctrl[`CTRL_UV_RETRY_BIT]
    |=> retryState == hotswap_pkg::FS_WAIT && retryLimit == RETRY_LAST)
    else $error("undervoltage retry wait not started");

  ovHold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ovEvent && !uvEvent && !ocEvent && !ctrl[`CTRL_OV_RETRY_BIT]
    |=> retryState == hotswap_pkg::FS_HOLD ##1 !switchOn)
    else $error("overvoltage without retry did not hold off");

  faultSet_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ocEvent |=> fault[`FLT_OC_BIT])
    else $error("overcurrent not logged");

  pinFlag_a: assert property (@(posedge mclk) disable iff (!arst_n)
    pinChange |=> fault[`FLT_PIN_BIT])
    else $error("pin change not logged");

  alertRaise_a: assert property (@(posedge mclk) disable iff (!arst_n)
    alertSet |=> alertPending ##1 !alert_n)
    else $error("enabled event did not pull the alert low");

endmodule

// ### rtl/hotswap_consts.svh
// Register offsets, field positions, reset values and timing figures of the
// hot swap control, alert-enable and fault-log register group.
// Assumes a 20 MHz mclk and a command byte that selects one register byte.
`ifndef HOTSWAP_CONSTS_SVH
`define HOTSWAP_CONSTS_SVH

// Command byte codes.
`define ADDR_CTRL_HI 8'h00
`define ADDR_CTRL_LO 8'h01
`define ADDR_ALERT_HI 8'h02
`define ADDR_ALERT_LO 8'h03
`define ADDR_FAULT 8'h04
`define ADDR_ALERT_CTRL 8'h1c

// Reset values.
`define RST_CTRL 16'hbb02
`define RST_ALERT 16'h0000
`define RST_FAULT 8'h00
`define RST_ALERT_CTRL 8'h00

// Control register bits, first byte in the upper half.
`define CTRL_MASK_BIT 15
`define CTRL_DELAY_BIT 14
`define CTRL_POL_BIT 13
`define CTRL_GROUP_BIT 12
`define CTRL_SWITCH_BIT 11
`define CTRL_OC_RETRY_BIT 10
`define CTRL_UV_RETRY_BIT 9
`define CTRL_OV_RETRY_BIT 8
`define CTRL_GOOD_FIELD 7:6
`define CTRL_LOW_FIELD 5:4
`define CTRL_HIGH_FIELD 3:2
`define CTRL_RANGE_FIELD 1:0
`define SWITCH_DATA_BIT 3

// Alert enable halves and alert-control bits.
`define ALERT_FAULT_FIELD 15:8
`define ALERT_ADC_FIELD 7:0
`define ACTL_CLEAR_BIT 7
`define ACTL_FORCE_BIT 6

// Fault log bits.
`define FLT_OV_BIT 0
`define FLT_UV_BIT 1
`define FLT_OC_BIT 2
`define FLT_PB_BIT 3
`define FLT_PIN_BIT 4

// Timing figures.
`define MCLK_HZ 20000000
`define DEBOUNCE_MS 50
`define RETRY_MS 50
`define OC_RETRY_TICKS 256
`define TIMER_TICK_DEFAULT 1

`endif

// ### rtl/hotswap_pkg.sv
// Types shared by the hot swap register group.
// Assumes the constants header is included by the design files.
package hotswap_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [23:0] count_t;
  typedef enum logic [1:0] {FS_RUN, FS_WAIT, FS_HOLD} retry_state_e;
endpackage

// ### verif/host_model.sv
// Host model for the byte command port of the hot swap register group.
// Assumes the device answers every taken command with one rspValid pulse on linkClk.
module host_model (
  // Link clock.
  input wire logic linkClk,
  // Command request.
  output logic cmdStrobe,
  output logic cmdWrite,
  output logic cmdGroup,
  output logic [7:0] cmdAddr,
  output logic [7:0] cmdData,
  // Command answer.
  input wire logic cmdBusy,
  input wire logic rspValid,
  input wire logic [7:0] rspData
);
  timeunit 1ns;
  timeprecision 1ps;
  int hung = 0;
  int busyBad = 0;

  // The port idles quiet from time zero.
  initial begin
    cmdStrobe = 1'b0;
    cmdWrite = 1'b0;
    cmdGroup = 1'b0;
    cmdAddr = 8'h00;
    cmdData = 8'h00;
  end

  // One command: a strobe of one cycle, then a bounded wait for the answer.
  // Address and data are inverted after the strobe so a late sample shows up as a wrong value.
  task automatic xfer(input logic w, input logic g, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(negedge linkClk);
    cmdStrobe = 1'b1;
    cmdWrite = w;
    cmdGroup = g;
    cmdAddr = a;
    cmdData = d;
    @(negedge linkClk);
    cmdStrobe = 1'b0;
    cmdAddr = ~a;
    cmdData = ~d;
    // The strobe was taken on the rising edge just passed.
    if (cmdBusy !== 1'b1) begin
      busyBad++;
      $display("[FAIL] %0t command port not busy after strobe", $time);
    end
    // The answer crosses three slow mclk stages, so it can take 15 link cycles.
    while (rspValid !== 1'b1 && n < 32) begin
      @(negedge linkClk);
      n++;
    end
    if (n >= 32) begin
      hung++;
      $display("[FAIL] %0t no answer from command port", $time);
    end
    q = rspData;
  endtask
endmodule

// ### verif/hotswap_control_alert_fault_regs_test.sv
// Self-checking bench for the hot swap control, alert-enable and fault-log registers.
// Assumes the host model drives the command port and events are driven on mclk falls.
`define CHK(g, e) begin \
  samplesChecked++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("[FAIL] %0t mismatch got %h expected %h", $time, (g), (e)); \
  end \
end

module hotswap_control_alert_fault_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic linkClk = 1'b0;
  logic arst_n = 1'b0;
  logic turnOnPin = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [7:0] adc = 8'h00;
  logic cmdStrobe, cmdWrite, cmdGroup, cmdBusy, rspValid, switchOn, alert_n;
  logic [7:0] cmdAddr, cmdData, rspData, q, d, f;
  logic [1:0] goodSel, lowSel, highSel, rangeSel, m;
  int errors = 0;
  int samplesChecked = 0;
  int cycles = 0;

  // The two clocks run free and unrelated.
  always #25 mclk = ~mclk;
  always #6 linkClk = ~linkClk;

  // Host side and device under test.
  host_model host (.linkClk(linkClk), .cmdStrobe(cmdStrobe), .cmdWrite(cmdWrite),
    .cmdGroup(cmdGroup), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdBusy(cmdBusy),
    .rspValid(rspValid), .rspData(rspData));
  hotswap_control_alert_fault_regs #(.DEBOUNCE_CYCLES(20), .RETRY_CYCLES(30),
    .TIMER_TICK_CYCLES(1)) uut (.mclk(mclk), .arst_n(arst_n), .linkClk(linkClk),
    .cmdStrobe(cmdStrobe), .cmdWrite(cmdWrite), .cmdGroup(cmdGroup), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdBusy(cmdBusy), .rspValid(rspValid), .rspData(rspData),
    .turnOnPin(turnOnPin), .ovEvent(ev[0]), .uvEvent(ev[1]), .ocEvent(ev[2]),
    .powerBadEvent(ev[3]), .switchShortEvent(ev[5]), .switchBadEvent(ev[6]),
    .nvWriteDoneEvent(ev[7]), .adcAlarmEvent(adc), .switchOn(switchOn),
    .goodThresholdSel(goodSel), .lowThresholdSel(lowSel), .highThresholdSel(highSel),
    .supplyRangeSel(rangeSel), .alert_n(alert_n));

  // A hung handshake still ends the run with a verdict.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("[FAIL] %0t timeout waiting for tests", $time);
      close_out();
    end
  end

  // Verdict and end of run.
  task automatic close_out();
    errors += host.hung;
    errors += host.busyBad;
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic waitm(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Writes wait two mclk more so registered outputs have settled.
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic g = 1'b0);
    host.xfer(1'b1, g, a, v, q);
    waitm(2);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, 1'b0, a, 8'h00, q);
    `CHK(q, e)
    `CHK(cmdBusy, 1'b0)
  endtask

  // One-cycle event pulses, then three cycles for the flag and alert to land.
  task automatic pulse(input logic [7:0] fe, input logic [7:0] ce);
    @(negedge mclk);
    ev = fe;
    adc = ce;
    @(negedge mclk);
    ev = 8'h00;
    adc = 8'h00;
    waitm(3);
  endtask

  // Main sequence of tests.
  initial begin
    logic [7:0] ra [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h1c};
    logic [7:0] re [6] = '{8'hbb, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    waitm(4);
    for (int i = 0; i < 6; i++) begin
      rdchk(ra[i], re[i]);
    end
    rdchk(8'h10, 8'h00);
    `CHK(switchOn, 1'b1)
    `CHK({goodSel, lowSel, highSel, rangeSel}, 8'h02)
    `CHK(alert_n, 1'b1)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      d = {m, m, m, m};
      wr(8'h01, d);
      `CHK(goodSel, m)
      `CHK(lowSel, m)
      `CHK(highSel, m)
      `CHK(rangeSel, m)
      rdchk(8'h01, d);
    end
    $display("test fields done");
    wr(8'h02, 8'h5a, 1'b1);
    rdchk(8'h02, 8'h5a);
    wr(8'h00, 8'hab);
    wr(8'h02, 8'h00, 1'b1);
    rdchk(8'h02, 8'h5a);
    wr(8'h02, 8'h00);
    wr(8'h00, 8'ha3);
    `CHK(switchOn, 1'b0)
    wr(8'h00, 8'hab);
    `CHK(switchOn, 1'b1)
    $display("test group and switch done");
    // The log is cleared before enabling, so the second pulse sets a fresh flag.
    for (int k = 0; k < 8; k++) begin
      if (k != 4) begin
        f = 8'h01 << k;
        pulse(f, 8'h00);
        `CHK(alert_n, 1'b1)
        wr(8'h04, 8'h00);
        wr(8'h02, f);
        pulse(f, 8'h00);
        `CHK(alert_n, 1'b0)
        rdchk(8'h04, f);
        wr(8'h04, 8'h00);
        wr(8'h1c, 8'h80);
        `CHK(alert_n, 1'b1)
        rdchk(8'h04, 8'h00);
      end
    end
    wr(8'h02, 8'h00);
    for (int k = 0; k < 8; k++) begin
      f = 8'h01 << k;
      wr(8'h03, f);
      pulse(8'h00, ~f);
      `CHK(alert_n, 1'b1)
      pulse(8'h00, f);
      `CHK(alert_n, 1'b0)
      wr(8'h1c, 8'h80);
    end
    wr(8'h03, 8'h00);
    wr(8'h1c, 8'h40);
    `CHK(alert_n, 1'b0)
    wr(8'h1c, 8'h00);
    `CHK(alert_n, 1'b1)
    $display("test alerts done");
    wr(8'h04, 8'h01);
    wr(8'h02, 8'h10);
    turnOnPin = 1'b1;
    waitm(8);
    rdchk(8'h04, 8'h11);
    `CHK(alert_n, 1'b0)
    wr(8'h1c, 8'h80);
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h2b);
    turnOnPin = 1'b0;
    waitm(8);
    rdchk(8'h04, 8'h10);
    `CHK(switchOn, 1'b0)
    $display("test pin done");
    // Active low with debounce: the low pin becomes a request as the write lands.
    wr(8'h00, 8'h43);
    waitm(8);
    `CHK(switchOn, 1'b0)
    waitm(20);
    `CHK(switchOn, 1'b1)
    wr(8'h00, 8'h03);
    `CHK(switchOn, 1'b0)
    turnOnPin = 1'b1;
    waitm(4);
    turnOnPin = 1'b0;
    waitm(8);
    `CHK(switchOn, 1'b1)
    $display("test debounce done");
    for (int k = 0; k < 2; k++) begin
      pulse(8'h01 << k, 8'h00);
      waitm(20);
      `CHK(switchOn, 1'b0)
      waitm(20);
      `CHK(switchOn, 1'b1)
    end
    pulse(8'h04, 8'h00);
    waitm(300);
    `CHK(switchOn, 1'b0)
    wr(8'h00, 8'h0f);
    `CHK(switchOn, 1'b1)
    pulse(8'h04, 8'h00);
    waitm(200);
    `CHK(switchOn, 1'b0)
    waitm(70);
    `CHK(switchOn, 1'b1)
    // Overvoltage with its retry off must hold off past the retry wait.
    wr(8'h00, 8'h0e);
    pulse(8'h01, 8'h00);
    waitm(40);
    `CHK(switchOn, 1'b0)
    wr(8'h00, 8'h0f);
    `CHK(switchOn, 1'b1)
    $display("test retry done");
    close_out();
  end
endmodule
